// ---- core/cogc_map.svh ----
// Register map, field positions, reset values and timing counts
`ifndef COGC_MAP_SVH
`define COGC_MAP_SVH

// ----------------------------------------------------------------
// Register indices and reset values
// ----------------------------------------------------------------
`define COGC_REG_COUNT     7
`define COGC_IDX_MODE      3'h0
`define COGC_IDX_PROC_FIX  3'h1
`define COGC_IDX_BUS       3'h2
`define COGC_IDX_MEM       3'h3
`define COGC_IDX_MEM_RSVD  3'h4
`define COGC_IDX_PERIPH    3'h5
`define COGC_IDX_FUTURE    3'h6
`define COGC_MODE_RST      8'h0C
`define COGC_ENA_RST       8'hFF

// ----------------------------------------------------------------
// Writable bits; reserved bits keep their reset value
// ----------------------------------------------------------------
`define COGC_MODE_WMASK    8'h7F
`define COGC_PROC_WMASK    8'hCF
`define COGC_BUS_WMASK     8'h7F
`define COGC_MEM_WMASK     8'hFF
`define COGC_RSVD_WMASK    8'h00
`define COGC_PERIPH_WMASK  8'h13

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define COGC_F_SPREAD_TYPE 5
`define COGC_F_SPREAD_AMT  4
`define COGC_F_FIXA_SEL    3
`define COGC_F_FIXB_SEL    2
`define COGC_F_FIXA_EN     7
`define COGC_F_FIXB_EN     6
`define COGC_F_FREE_EN     6
`define COGC_F_IRQC_EN     4

// ----------------------------------------------------------------
// Serial bus and timing
// ----------------------------------------------------------------
`define COGC_DEV_ADDR      7'h69
`define COGC_BLOCK_COUNT   8'h07
`define COGC_CLK_HZ        10000000
`define COGC_WAKE_MS       3
`define COGC_WAKE_CYC      (`COGC_WAKE_MS * (`COGC_CLK_HZ / 1000))
`define COGC_SYNC_W        6

`endif

// ---- core/cogc_pkg.sv ----
// Types shared by the clock gating block
package cogc_pkg;
	typedef logic [7:0] cogc_byte_t;
	typedef enum logic [1:0] {
		COGC_NORMAL   = 2'b00,
		COGC_TEST     = 2'b01,
		COGC_SPREAD   = 2'b10,
		COGC_TRISTATE = 2'b11
	} cogc_mode_t;
	typedef enum logic [1:0] {
		PWR_RUN   = 2'b00,
		PWR_DRAIN = 2'b01,
		PWR_OFF   = 2'b10,
		PWR_WAKE  = 2'b11
	} cogc_pwr_t;
	typedef enum logic [2:0] {
		SER_IDLE = 3'b000,
		SER_ADDR = 3'b001,
		SER_AACK = 3'b010,
		SER_RX   = 3'b011,
		SER_RACK = 3'b100,
		SER_TX   = 3'b101,
		SER_HACK = 3'b110
	} cogc_ser_t;
endpackage : cogc_pkg

// ---- core/cogc_reg_if.sv ----
// Register access path between the serial slave and the register file
`timescale 1ns/100ps
`default_nettype none
interface cogc_reg_if;
	logic             wr_stb;
	logic [2:0]       widx;
	cogc_pkg::cogc_byte_t wdata;
	logic [3:0]       ridx;
	cogc_pkg::cogc_byte_t rdata;
	modport master (output wr_stb, widx, wdata, ridx, input rdata);
	modport regs   (input wr_stb, widx, wdata, ridx, output rdata);
endinterface : cogc_reg_if
`default_nettype wire

// ---- core/cogc_sync.sv ----
// Two-stage synchroniser bank for asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module cogc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Pins and synchronised copies
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// Idle pins are high, so both stages reset high
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= '1;
			q        <= '1;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule : cogc_sync
`default_nettype wire

// ---- core/cogc_ser_slave.sv ----
// Two-wire serial slave: block write and block read of the config bytes
`timescale 1ns/100ps
`default_nettype none
`include "cogc_map.svh"
module cogc_ser_slave (
	// Clock and reset
	input  wire logic   clk,
	input  wire logic   rst_b,
	// Synchronised serial pins
	input  wire logic   scl_s,
	input  wire logic   sda_s,
	output var  logic   sda_oe,
	// Register access
	cogc_reg_if.master  rb
);
	import cogc_pkg::*;

	cogc_ser_t  st_reg, st_next;
	logic [3:0] bitc_reg, bitc_next;
	logic [3:0] nbyte_reg, nbyte_next;
	cogc_byte_t sh_reg, sh_next;
	cogc_byte_t wdata_reg, wdata_next;
	logic [2:0] widx_reg, widx_next;
	logic       rd_reg, rd_next;
	logic       oe_reg, oe_next;
	logic       wr_reg, wr_next;
	logic       scl_d_reg, sda_d_reg;
	logic       rise, fall, start, stop;

	assign rise  = scl_s & ~scl_d_reg;
	assign fall  = ~scl_s & scl_d_reg;
	assign start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign sda_oe    = oe_reg;
	assign rb.wr_stb = wr_reg;
	assign rb.widx   = widx_reg;
	assign rb.wdata  = wdata_reg;
	assign rb.ridx   = nbyte_reg;

	always_comb begin
		st_next    = st_reg;
		bitc_next  = bitc_reg;
		nbyte_next = nbyte_reg;
		sh_next    = sh_reg;
		wdata_next = wdata_reg;
		widx_next  = widx_reg;
		rd_next    = rd_reg;
		oe_next    = oe_reg;
		wr_next    = 1'b0;
		if (start) begin
			st_next    = SER_ADDR;
			bitc_next  = 4'h0;
			nbyte_next = 4'h0;
			oe_next    = 1'b0;
		end else if (stop) begin
			st_next = SER_IDLE;
			oe_next = 1'b0;
		end else begin
			unique case (st_reg)
			SER_IDLE: begin
				st_next = SER_IDLE;
			end
			SER_ADDR, SER_RX: begin
				if (rise) begin
					sh_next   = {sh_reg[6:0], sda_s};
					bitc_next = bitc_reg + 4'h1;
				end else if (fall && bitc_reg == 4'h8) begin
					bitc_next = 4'h0;
					oe_next   = 1'b1;
					st_next   = SER_RACK;
					if (st_reg == SER_ADDR) begin
						st_next = SER_AACK;
						rd_next = sh_reg[0];
						if (sh_reg[7:1] != `COGC_DEV_ADDR) begin
							st_next = SER_IDLE;
							oe_next = 1'b0;
						end
					end else begin
						// Command and count bytes are skipped
						if (nbyte_reg != 4'hF)
							nbyte_next = nbyte_reg + 4'h1;
						if (nbyte_reg >= 4'h2 && nbyte_reg < 4'h9) begin
							wr_next    = 1'b1;
							widx_next  = 3'(nbyte_reg - 4'h2);
							wdata_next = sh_reg;
						end
					end
				end
			end
			SER_AACK, SER_RACK: begin
				if (fall) begin
					oe_next = 1'b0;
					st_next = SER_RX;
					if (st_reg == SER_AACK && rd_reg) begin
						st_next = SER_TX;
						sh_next = `COGC_BLOCK_COUNT;
						oe_next = ~sh_next[7];
					end
				end
			end
			SER_TX: begin
				if (fall && bitc_reg == 4'h7) begin
					st_next = SER_HACK;
					oe_next = 1'b0;
				end else if (fall) begin
					sh_next   = {sh_reg[6:0], 1'b0};
					oe_next   = ~sh_reg[6];
					bitc_next = bitc_reg + 4'h1;
				end
			end
			SER_HACK: begin
				if (rise && sda_s) begin
					st_next = SER_IDLE;
				end else if (fall) begin
					st_next   = SER_TX;
					sh_next   = rb.rdata;
					oe_next   = ~rb.rdata[7];
					bitc_next = 4'h0;
					if (nbyte_reg != 4'hF)
						nbyte_next = nbyte_reg + 4'h1;
				end
			end
			default: begin
				st_next = SER_IDLE;
				oe_next = 1'b0;
			end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg    <= SER_IDLE;
			bitc_reg  <= 4'h0;
			nbyte_reg <= 4'h0;
			sh_reg    <= 8'h00;
			wdata_reg <= 8'h00;
			widx_reg  <= 3'h0;
			rd_reg    <= 1'b0;
			oe_reg    <= 1'b0;
			wr_reg    <= 1'b0;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			st_reg    <= st_next;
			bitc_reg  <= bitc_next;
			nbyte_reg <= nbyte_next;
			sh_reg    <= sh_next;
			wdata_reg <= wdata_next;
			widx_reg  <= widx_next;
			rd_reg    <= rd_next;
			oe_reg    <= oe_next;
			wr_reg    <= wr_next;
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end
endmodule : cogc_ser_slave
`default_nettype wire

// ---- core/cogc_top.sv ----
// Output clock gating, power management and serial configuration bytes
`timescale 1ns/100ps
`default_nettype none
`include "cogc_map.svh"

// Function
// [RL1] Byte 0 bits 1:0 pick tri-state, spread, test or normal mode.
// [RL2] In spread mode byte 0 bit 5 picks centre or down spreading.
// [RL3] In spread mode byte 0 bit 4 picks wide or narrow deviation.
// [RL4] Byte 0 bits 3 and 2 pick fast or slow fixed clocks; reset fast.
// [RL5] Host keeps byte 0 bit 6 zero; bit 7 reserved zero.
// [RL6] Cleared enable bit holds its output low; all enables reset set.
// [RL7] Byte 1 enables both fixed clocks and processor clocks 3 to 0.
// [RL8] Byte 2 enables free-running bus clock and bus clocks 5 to 0.
// [RL9] Byte 3 enables memory clocks; bytes 4 and 6 reserved ones.
// [RL10] Byte 5 enables interrupt-controller clock and both references.
// [RL11] Processor stop low parks processor clocks low; others keep running.
// [RL12] Restarted processor clocks begin with a full high phase.
// [RL13] Controller keeps processor stop high 100 cycles between stops.
// [RL14] Processor clocks start and stop within four processor cycles.
// [RL15] Processor stop is synchronised before use.
// [RL16] Stop inputs act within one free-running bus clock rising edge.
// [RL17] Clocks valid within 3 ms after power-up; stop quickly on entry.
// [RL18] Reference and interrupt clocks stop apart from counted groups.
// [RL19] Power-down entry and exit never give short or long pulses.
// [RL20] Free-running bus clock matches bus clocks, ignores bus stop.
// [RL21] Power-down and stop inputs act only with mode select low.
// [RL22] Power-down parks all clocks low before oscillator turns off.
module cogc_top #(
	parameter int unsigned WAKE_CYCLES = `COGC_WAKE_CYC
) (
	// Clock and reset
	input  wire logic       CLK,
	input  wire logic       RST_B,
	// Power management pins
	input  wire logic       MODE_SEL,
	input  wire logic       PROC_CLOCK_STOP_N,
	input  wire logic       BUS_CLOCK_STOP_N,
	input  wire logic       POWER_DOWN_N,
	// Serial configuration pins
	input  wire logic       SER_CLK,
	input  wire logic       SER_DATA_I,
	output var  logic       SER_DATA_O,
	output var  logic       SER_DATA_OE,
	// Clock outputs
	output var  logic [3:0] PROC_CLOCK_OUT,
	output var  logic [5:0] PERIPH_BUS_CLOCK_OUT,
	output var  logic       FREE_RUNNING_BUS_CLOCK,
	output var  logic [7:0] MEM_CLOCK_OUT,
	output var  logic [1:0] FIXED_CLOCK_OUT,
	output var  logic [1:0] REF_CLOCK_OUT,
	output var  logic       INTERRUPT_CTRL_CLOCK_OUT,
	// Synthesiser controls
	output var  logic       CLOCK_OUT_OE,
	output var  logic       OSC_ENABLE,
	output var  cogc_pkg::cogc_mode_t MODE_STATE,
	output var  logic       SPREAD_DOWN,
	output var  logic       SPREAD_NARROW
);
	import cogc_pkg::*;

	localparam logic [14:0] WAKE_LAST = 15'(WAKE_CYCLES - 1);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [`COGC_SYNC_W-1:0] pin_s;
	logic mode_s, proc_stop_s, bus_stop_s, pd_s, scl_s, sda_s;
	logic pm_on, pd_req, proc_hold, bus_hold;

	cogc_sync #(.W(`COGC_SYNC_W)) u_sync (
		.clk   (CLK),
		.rst_b (RST_B),
		.d     ({MODE_SEL, PROC_CLOCK_STOP_N, BUS_CLOCK_STOP_N,
		         POWER_DOWN_N, SER_CLK, SER_DATA_I}),
		.q     (pin_s)
	); // RL15
	assign {mode_s, proc_stop_s, bus_stop_s, pd_s, scl_s, sda_s} = pin_s;
	assign pm_on     = ~mode_s; // RL21
	assign pd_req    = pm_on & ~pd_s;
	assign proc_hold = pm_on & ~proc_stop_s;
	assign bus_hold  = pm_on & ~bus_stop_s;

	// ------------------------------------------------------------
	// Configuration bytes
	// ------------------------------------------------------------
	cogc_reg_if rb ();
	cogc_byte_t cfg_reg [`COGC_REG_COUNT];
	cogc_byte_t cfg_next [`COGC_REG_COUNT];
	cogc_mode_t mode;

	cogc_ser_slave u_ser (
		.clk    (CLK),
		.rst_b  (RST_B),
		.scl_s  (scl_s),
		.sda_s  (sda_s),
		.sda_oe (SER_DATA_OE),
		.rb     (rb.master)
	);

	function automatic cogc_byte_t wmask(input logic [2:0] idx);
		unique case (idx)
		`COGC_IDX_MODE:     return `COGC_MODE_WMASK;
		`COGC_IDX_PROC_FIX: return `COGC_PROC_WMASK;
		`COGC_IDX_BUS:      return `COGC_BUS_WMASK;
		`COGC_IDX_MEM:      return `COGC_MEM_WMASK;
		`COGC_IDX_PERIPH:   return `COGC_PERIPH_WMASK;
		default:            return `COGC_RSVD_WMASK;
		endcase
	endfunction : wmask

	// Reserved bits are masked, so they keep their reset value
	always_comb begin
		for (int i = 0; i < `COGC_REG_COUNT; i++) begin
			cfg_next[i] = cfg_reg[i];
			if (rb.wr_stb && rb.widx == 3'(i))
				cfg_next[i] = (cfg_reg[i] & ~wmask(3'(i)))
				            | (rb.wdata & wmask(3'(i))); // RL9
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cfg_reg[0] <= `COGC_MODE_RST; // RL4
			for (int i = 1; i < `COGC_REG_COUNT; i++)
				cfg_reg[i] <= `COGC_ENA_RST; // RL6
		end else begin
			for (int i = 0; i < `COGC_REG_COUNT; i++)
				cfg_reg[i] <= cfg_next[i];
		end
	end

	assign rb.rdata = (rb.ridx < 4'h7) ? cfg_reg[rb.ridx[2:0]] : 8'h00;
	assign mode     = cogc_mode_t'(cfg_reg[`COGC_IDX_MODE][1:0]);

	// ------------------------------------------------------------
	// Power-down sequencer and clock phases
	// ------------------------------------------------------------
	cogc_pwr_t   pwr_reg, pwr_next;
	logic [14:0] wake_reg, wake_next;
	logic [1:0]  div_reg, div_next;
	logic        osc_reg, osc_next;
	logic        all_run_reg, all_run_next, aux_run_reg, aux_run_next;

	// The oscillator stops only once every gated group is parked low
	always_comb begin
		pwr_next  = pwr_reg;
		wake_next = wake_reg;
		unique case (pwr_reg)
		PWR_RUN:   if (pd_req) pwr_next = PWR_DRAIN;
		PWR_DRAIN: if (!all_run_reg && !aux_run_reg)
			pwr_next = PWR_OFF; // RL22
		PWR_OFF: begin
			wake_next = 15'h0000;
			if (!pd_req) pwr_next = PWR_WAKE;
		end
		PWR_WAKE: begin
			wake_next = wake_reg + 15'h0001;
			if (wake_reg >= WAKE_LAST) pwr_next = PWR_RUN; // RL17
		end
		endcase
		osc_next = (pwr_next != PWR_OFF);
		div_next = osc_reg ? div_reg + 2'h1 : div_reg;
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pwr_reg  <= PWR_RUN;
			wake_reg <= 15'h0000;
			div_reg  <= 2'h0;
			osc_reg  <= 1'b1;
		end else begin
			pwr_reg  <= pwr_next;
			wake_reg <= wake_next;
			div_reg  <= div_next;
			osc_reg  <= osc_next;
		end
	end

	// ------------------------------------------------------------
	// Glitch-free gates and output flops
	// ------------------------------------------------------------
	logic proc_run_reg, proc_run_next, bus_run_reg, bus_run_next;
	logic pf, ps;
	cogc_byte_t c0, c1, c2, c3, c5;

	// A gate only changes when its phase is about to be low
	function automatic logic gate_upd(input logic cur, input logic want,
	                                  input logic low_next);
		return low_next ? want : cur;
	endfunction : gate_upd

	assign c0 = cfg_reg[`COGC_IDX_MODE];
	assign c1 = cfg_reg[`COGC_IDX_PROC_FIX];
	assign c2 = cfg_reg[`COGC_IDX_BUS];
	assign c3 = cfg_reg[`COGC_IDX_MEM];
	assign c5 = cfg_reg[`COGC_IDX_PERIPH];

	always_comb begin
		pf = div_next[0];
		ps = div_next[1];
		proc_run_next = gate_upd(proc_run_reg, !proc_hold, !pf); // RL11 RL12 RL14
		bus_run_next  = gate_upd(bus_run_reg, !bus_hold, !ps); // RL16
		all_run_next  = gate_upd(all_run_reg, pwr_reg == PWR_RUN,
		                         div_next == 2'h0); // RL19 RL22
		aux_run_next  = gate_upd(aux_run_reg, pwr_reg == PWR_RUN,
		                         !pf); // RL18
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			proc_run_reg             <= 1'b0;
			bus_run_reg              <= 1'b0;
			all_run_reg              <= 1'b0;
			aux_run_reg              <= 1'b0;
			PROC_CLOCK_OUT           <= 4'h0;
			PERIPH_BUS_CLOCK_OUT     <= 6'h00;
			FREE_RUNNING_BUS_CLOCK   <= 1'b0;
			MEM_CLOCK_OUT            <= 8'h00;
			FIXED_CLOCK_OUT          <= 2'h0;
			REF_CLOCK_OUT            <= 2'h0;
			INTERRUPT_CTRL_CLOCK_OUT <= 1'b0;
			CLOCK_OUT_OE             <= 1'b1;
			OSC_ENABLE               <= 1'b1;
			MODE_STATE               <= COGC_NORMAL;
			SPREAD_DOWN              <= 1'b0;
			SPREAD_NARROW            <= 1'b0;
			SER_DATA_O               <= 1'b0;
		end else begin
			proc_run_reg <= proc_run_next;
			bus_run_reg  <= bus_run_next;
			all_run_reg  <= all_run_next;
			aux_run_reg  <= aux_run_next;
			PROC_CLOCK_OUT <= {4{pf & proc_run_next & all_run_next}}
			                & c1[3:0]; // RL7 RL11
			PERIPH_BUS_CLOCK_OUT <= {6{ps & bus_run_next & all_run_next}}
			                      & c2[5:0]; // RL8
			FREE_RUNNING_BUS_CLOCK <= ps & all_run_next
			                        & c2[`COGC_F_FREE_EN]; // RL20
			MEM_CLOCK_OUT <= {8{pf & all_run_next}} & c3; // RL9
			FIXED_CLOCK_OUT[1] <= (c0[`COGC_F_FIXA_SEL] ? pf : ps)
			                    & all_run_next & c1[`COGC_F_FIXA_EN]; // RL4
			FIXED_CLOCK_OUT[0] <= (c0[`COGC_F_FIXB_SEL] ? pf : ps)
			                    & all_run_next & c1[`COGC_F_FIXB_EN]; // RL4
			REF_CLOCK_OUT <= {2{pf & aux_run_next}} & c5[1:0]; // RL10
			INTERRUPT_CTRL_CLOCK_OUT <= pf & aux_run_next
			                          & c5[`COGC_F_IRQC_EN]; // RL10
			CLOCK_OUT_OE  <= (mode != COGC_TRISTATE); // RL1
			OSC_ENABLE    <= osc_next;
			MODE_STATE    <= mode; // RL1
			SPREAD_DOWN   <= (mode == COGC_SPREAD)
			               & c0[`COGC_F_SPREAD_TYPE]; // RL2
			SPREAD_NARROW <= (mode == COGC_SPREAD)
			               & c0[`COGC_F_SPREAD_AMT]; // RL3
			SER_DATA_O    <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	sequence proc_stop_held;
		(proc_hold && pwr_reg == PWR_RUN)[*4];
	endsequence
	sequence bus_stop_held;
		(bus_hold && pwr_reg == PWR_RUN)[*4];
	endsequence

	tristate_oe_a: assert property ( // RL1
		mode == COGC_TRISTATE |=> !CLOCK_OUT_OE)
		else $error("outputs not tri-stated in tri-state mode");
	spread_type_a: assert property ( // RL2
		(mode == COGC_SPREAD) |=> SPREAD_DOWN == $past(c0[5]))
		else $error("spread type does not follow byte 0 bit 5");
	spread_amt_a: assert property ( // RL3
		mode != COGC_SPREAD |=> !SPREAD_NARROW)
		else $error("spread amount active outside spread mode");
	fixed_slow_a: assert property ( // RL4
		!c0[3] && !$stable(div_reg) |=> FIXED_CLOCK_OUT[1] |-> div_reg[1])
		else $error("slow fixed clock not on slow phase");
	enable_low_a: assert property ( // RL6
		!c3[0] |=> !MEM_CLOCK_OUT[0])
		else $error("disabled memory clock not held low");
	proc_park_a: assert property ( // RL11
		proc_stop_held |-> PROC_CLOCK_OUT == 4'h0)
		else $error("processor clocks still running under stop");
	full_pulse_a: assert property ( // RL12
		$rose(PERIPH_BUS_CLOCK_OUT[0]) && c2[0] |=> PERIPH_BUS_CLOCK_OUT[0])
		else $error("shortened bus clock high phase");
	bus_park_a: assert property ( // RL16
		bus_stop_held |-> PERIPH_BUS_CLOCK_OUT == 6'h00)
		else $error("bus clocks still running under stop");
	free_run_a: assert property ( // RL20
		c2[6] |=> FREE_RUNNING_BUS_CLOCK == (div_reg[1] & all_run_reg))
		else $error("free-running bus clock gated by stop");
	mode_ignore_a: assert property ( // RL21
		mode_s && pwr_reg == PWR_RUN |=> pwr_reg == PWR_RUN)
		else $error("power-down taken with mode select high");
	pd_drain_a: assert property ( // RL22
		pwr_reg == PWR_RUN && pd_req |-> ##[1:6] pwr_reg == PWR_OFF)
		else $error("power-down entry too slow");
	off_low_a: assert property ( // RL17
		pwr_reg == PWR_OFF |-> !OSC_ENABLE && PROC_CLOCK_OUT == 4'h0
		                       && MEM_CLOCK_OUT == 8'h00)
		else $error("clocks or oscillator live while powered down");
endmodule : cogc_top
`default_nettype wire

// ---- dv/cogc_host.sv ----
// Serial host model that drives the configuration bus
`timescale 1ns/100ps
`default_nettype none
module cogc_host (
	// Clock
	input  wire logic clk,
	// Serial wires
	input  wire logic sda,
	output var  logic scl,
	output var  logic sda_low
);
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// One bit, data sampled mid-high; b=1 releases the wire
	task xbit(input logic b, output logic r);
		sda_low = ~b;
		tick(2);
		scl = 1'b1;
		tick(2);
		r = sda;
		tick(2);
		scl = 1'b0;
		tick(2);
	endtask : xbit
	task start;
		sda_low = 1'b0;
		tick(2);
		scl = 1'b1;
		tick(2);
		sda_low = 1'b1;
		tick(4);
		scl = 1'b0;
		tick(2);
	endtask : start
	task stop;
		sda_low = 1'b1;
		tick(2);
		scl = 1'b1;
		tick(4);
		sda_low = 1'b0;
		tick(4);
	endtask : stop
	task wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], r);
		end
		xbit(1'b1, r);
		ack = ~r;
	endtask : wbyte
	task rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			xbit(1'b1, r);
			d = {d[6:0], r};
		end
		xbit(last, r);
	endtask : rbyte
endmodule : cogc_host
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the clock gating block
`timescale 1ns/100ps
`default_nettype none
`include "cogc_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	$display("[ERR] %s exp %h got %h", nm, e, g); bad_count++; end end
module tb_top;
	import cogc_pkg::*;
	logic CLK = 1'b0, RST_B = 1'b0, MODE_SEL = 1'b0;
	logic PROC_CLOCK_STOP_N = 1'b1, BUS_CLOCK_STOP_N = 1'b1;
	logic POWER_DOWN_N = 1'b1, SER_DATA_O, SER_DATA_OE;
	logic scl, host_low, sda, FREE, IRQ, OE, OSC, SD, SN;
	logic [3:0] PROC;
	logic [5:0] BUS;
	logic [7:0] MEM;
	logic [1:0] FIX, REF;
	cogc_mode_t MST;
	int bad_count = 0, n_checks = 0, cyc = 0;
	cogc_byte_t regs[7], wv[7], msk[7];
	// Open-drain data wire with pull-up
	assign sda = ~(host_low | (SER_DATA_OE & ~SER_DATA_O));
	always #50 CLK = ~CLK;
	cogc_host u_cogc_host (.clk(CLK), .sda(sda), .scl(scl),
		.sda_low(host_low));
	cogc_top #(.WAKE_CYCLES(20)) u_cogc_top (.CLK(CLK), .RST_B(RST_B),
		.MODE_SEL(MODE_SEL), .PROC_CLOCK_STOP_N(PROC_CLOCK_STOP_N),
		.BUS_CLOCK_STOP_N(BUS_CLOCK_STOP_N), .POWER_DOWN_N(POWER_DOWN_N),
		.SER_CLK(scl), .SER_DATA_I(sda), .SER_DATA_O(SER_DATA_O),
		.SER_DATA_OE(SER_DATA_OE), .PROC_CLOCK_OUT(PROC),
		.PERIPH_BUS_CLOCK_OUT(BUS), .FREE_RUNNING_BUS_CLOCK(FREE),
		.MEM_CLOCK_OUT(MEM), .FIXED_CLOCK_OUT(FIX), .REF_CLOCK_OUT(REF),
		.INTERRUPT_CTRL_CLOCK_OUT(IRQ), .CLOCK_OUT_OE(OE),
		.OSC_ENABLE(OSC), .MODE_STATE(MST), .SPREAD_DOWN(SD),
		.SPREAD_NARROW(SN));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			conclude;
		end
	end
	task tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : tick
	function automatic logic [23:0] exp_run(input logic ps, bs);
		return {regs[1][3:0] & {4{ps}}, regs[2][5:0] & {6{bs}}, regs[2][6],
			regs[3], regs[1][7:6], regs[5][1:0], regs[5][4]};
	endfunction : exp_run
	// Marks outputs that toggled over 16 cycles; fc counts fixed[1] edges
	task watch(output logic [23:0] t, output int fc);
		logic [23:0] p, c;
		t = '0;
		fc = 0;
		p = {PROC, BUS, FREE, MEM, FIX, REF, IRQ};
		for (int i = 0; i < 16; i++) begin
			tick(1);
			c = {PROC, BUS, FREE, MEM, FIX, REF, IRQ};
			t |= c ^ p;
			fc += int'(c[4] ^ p[4]);
			p = c;
		end
	endtask : watch
	task wr_all;
		logic a, ok;
		u_cogc_host.start;
		u_cogc_host.wbyte(8'hD2, ok);
		u_cogc_host.wbyte(8'h00, a);
		u_cogc_host.wbyte(8'h07, a);
		for (int i = 0; i < 7; i++) begin
			u_cogc_host.wbyte(wv[i], a);
			ok &= a;
			regs[i] = (regs[i] & ~msk[i]) | (wv[i] & msk[i]);
		end
		u_cogc_host.stop;
		`CHK("write ack", 1'b1, ok)
	endtask : wr_all
	task rd_all;
		logic a;
		cogc_byte_t d;
		u_cogc_host.start;
		u_cogc_host.wbyte(8'hD3, a);
		u_cogc_host.rbyte(1'b0, d);
		`CHK("count", `COGC_BLOCK_COUNT, d)
		for (int i = 0; i < 7; i++) begin
			u_cogc_host.rbyte(i == 6, d);
			`CHK("byte", regs[i], d)
		end
		u_cogc_host.stop;
	endtask : rd_all
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		logic [23:0] t;
		int fc;
		logic a;
		logic [1:0] m;
		msk = '{`COGC_MODE_WMASK, `COGC_PROC_WMASK, `COGC_BUS_WMASK,
			`COGC_MEM_WMASK, `COGC_RSVD_WMASK, `COGC_PERIPH_WMASK,
			`COGC_RSVD_WMASK};
		regs = '{8'h0C, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
		void'($urandom(4357));
		tick(16);
		RST_B = 1'b1;
		tick(8);
		rd_all;
		u_cogc_host.start;
		u_cogc_host.wbyte(8'hA4, a);
		u_cogc_host.stop;
		`CHK("wrong addr ack", 1'b0, a)
		for (int k = 0; k < 4; k++) begin
			m = k[1:0];
			foreach (wv[i]) wv[i] = cogc_byte_t'($urandom);
			wv[0] = {2'b00, wv[0][5:2], m};
			wv[3][0] = k[0];
			wr_all;
			tick(3);
			`CHK("mode", cogc_mode_t'(m), MST)
			`CHK("oe", m != 2'b11, OE)
			`CHK("down", m == 2'b10 && regs[0][5], SD)
			`CHK("narrow", m == 2'b10 && regs[0][4], SN)
			watch(t, fc);
			`CHK("run", exp_run(1'b1, 1'b1), t)
			if (regs[1][7])
				`CHK("fixed rate", regs[0][3] ? 16 : 8, fc)
		end
		rd_all;
		wv = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
		wr_all;
		PROC_CLOCK_STOP_N = 1'b0;
		BUS_CLOCK_STOP_N = 1'b0;
		tick(8);
		watch(t, fc);
		`CHK("stopped", exp_run(1'b0, 1'b0), t)
		`CHK("parked low", 10'h000, {PROC, BUS})
		MODE_SEL = 1'b1;
		POWER_DOWN_N = 1'b0;
		tick(8);
		watch(t, fc);
		`CHK("pm off", exp_run(1'b1, 1'b1), t)
		`CHK("pd ignored", 1'b1, OSC)
		POWER_DOWN_N = 1'b1;
		MODE_SEL = 1'b0;
		PROC_CLOCK_STOP_N = 1'b1;
		BUS_CLOCK_STOP_N = 1'b1;
		tick(8);
		watch(t, fc);
		`CHK("restart", exp_run(1'b1, 1'b1), t)
		tick(200);
		POWER_DOWN_N = 1'b0;
		PROC_CLOCK_STOP_N = 1'b0;
		tick(10);
		`CHK("osc off", 1'b0, OSC)
		watch(t, fc);
		`CHK("pd quiet", 24'h000000, t)
		PROC_CLOCK_STOP_N = 1'b1;
		POWER_DOWN_N = 1'b1;
		tick(32);
		`CHK("osc on", 1'b1, OSC)
		watch(t, fc);
		`CHK("wake", exp_run(1'b1, 1'b1), t)
		rd_all;
		conclude;
	end
endmodule : tb_top
`default_nettype wire
